// ==== common/dma_link_if.sv ====
`timescale 1ns/1ps
interface dma_link_if;
  import dma_pkg::*;
  // outbound buffer access
  edb_t tx_edb;
  logic tx_xy;
  idx_t tx_idx;
  logic tx_own;
  cnt_t tx_cnt;
  byte_t tx_byte;
  logic tx_desc_wr;
  logic tx_xy_toggle;
  // inbound buffer access
  edb_t rx_edb;
  logic rx_xy;
  idx_t rx_idx;
  logic rx_own_x;
  logic rx_own_y;
  logic rx_buf_wr;
  byte_t rx_buf_data;
  logic rx_desc_wr;
  cnt_t rx_desc_cnt;
  logic rx_xy_toggle;
  // serial data registers
  byte_t ser_tx_data;
  logic ser_tx_wr;
  logic ser_tx_ready;
  byte_t ser_rx_data;
  logic ser_rx_valid;
  logic ser_rx_rd;
  logic [3:0] line_err;

  modport engine (
    output tx_edb, tx_xy, tx_idx, tx_desc_wr, rx_edb, rx_xy, rx_idx, rx_buf_wr,
    output rx_buf_data, rx_desc_wr, rx_desc_cnt, ser_tx_data, ser_tx_wr, ser_rx_rd,
    input tx_own, tx_cnt, tx_byte, tx_xy_toggle, rx_own_x, rx_own_y, rx_xy_toggle,
    input ser_tx_ready, ser_rx_data, ser_rx_valid, line_err
  );
  modport manager (
    input tx_edb, tx_xy, tx_idx, tx_desc_wr, rx_edb, rx_xy, rx_idx, rx_buf_wr,
    input rx_buf_data, rx_desc_wr, rx_desc_cnt, ser_tx_data, ser_tx_wr, ser_rx_rd,
    output tx_own, tx_cnt, tx_byte, tx_xy_toggle, rx_own_x, rx_own_y, rx_xy_toggle,
    output ser_tx_ready, ser_rx_data, ser_rx_valid, line_err
  );
endinterface

// ==== common/dma_pkg.sv ====
package dma_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

  // ***********************************************************
  // register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [15:0] IDX_TX_DEF = 16'hFFE0;
  localparam logic [15:0] IDX_TX_CSR = 16'hFFE1;
  localparam logic [15:0] IDX_RX_DEF = 16'hFFE4;
  localparam logic [15:0] IDX_RX_CSR = 16'hFFE5;

  // ***********************************************************
  // field layout and reset values
  // ***********************************************************
  localparam int DEF_EN_BIT = 7;
  localparam int DEF_CONT_BIT = 5;
  localparam int DEF_XY_BIT = 4;
  localparam int DEF_EDB_LSB = 0;
  localparam int CSR_OVR_BIT = 0;
  localparam int CSR_TO_BIT = 1;
  localparam int CSR_PP_BIT = 2;
  localparam int CSR_TOV_LSB = 3;
  localparam logic [7:0] DEF_WR_MASK = 8'hBB;
  localparam logic [7:0] CSR_FLAG_MASK = 8'h07;
  localparam logic [7:0] CSR_TOV_MASK = 8'h78;
  localparam logic [7:0] DEF_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [6:0] PKT_SIZE = 7'h40;

  // ***********************************************************
  // types
  // ***********************************************************
  typedef logic [1:0] edb_t;
  typedef logic [5:0] idx_t;
  typedef logic [6:0] cnt_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [6:0] {
    TX_IDLE = 7'h01,
    TX_LOOK = 7'h02,
    TX_FETCH = 7'h04,
    TX_PUSH = 7'h08,
    TX_DONE = 7'h10,
    TX_WAIT = 7'h20,
    TX_HALT = 7'h40
  } tx_state_e;

  typedef enum logic [6:0] {
    RX_IDLE = 7'h01,
    RX_LOOK = 7'h02,
    RX_FILL = 7'h04,
    RX_STORE = 7'h08,
    RX_COMMIT = 7'h10,
    RX_WAIT = 7'h20,
    RX_HALT = 7'h40
  } rx_state_e;

endpackage

// ==== hdl/buffer_manager.sv ====
`timescale 1ns/1ps
module buffer_manager (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // descriptor setup
  input wire logic init_wr,
  input wire dma_pkg::edb_t init_edb,
  input wire logic init_own,
  // host side selection
  input wire dma_pkg::edb_t host_edb,
  // host outbound packets
  input wire logic out_wr,
  input wire dma_pkg::idx_t out_idx,
  input wire dma_pkg::byte_t out_data,
  input wire logic out_commit,
  input wire dma_pkg::cnt_t out_cnt,
  output logic out_free,
  // host inbound packets
  output logic in_avail,
  output dma_pkg::cnt_t in_cnt,
  input wire dma_pkg::idx_t in_rd_idx,
  output dma_pkg::byte_t in_rd_data,
  input wire logic in_release,
  // serial port
  output dma_pkg::byte_t uart_tx_data,
  output logic uart_tx_valid,
  input wire logic uart_tx_ready,
  input wire dma_pkg::byte_t uart_rx_data,
  input wire logic uart_rx_valid,
  output logic uart_rx_ready,
  input wire logic [3:0] uart_line_err,
  // link to the transfer engine
  dma_link_if.manager link
);
  import dma_pkg::*;

  // ***********************************************************
  // storage: 4 blocks x 2 buffers x 64 bytes, block 0 usable like the rest
  // ***********************************************************
  byte_t mem_reg [512];
  cnt_t cnt_reg [8];
  logic [7:0] own_reg;
  logic [3:0] host_xy_reg;
  logic tx_tog_reg;
  logic rx_tog_reg;
  logic [2:0] host_sel;

  assign host_sel = {host_edb, host_xy_reg[host_edb]};

  // byte writes from host and engine
  always_ff @(posedge clk_sys)
  begin
    if (out_wr)
      mem_reg[{host_sel, out_idx}] <= out_data;
    if (link.rx_buf_wr)
      mem_reg[{link.rx_edb, link.rx_xy, link.rx_idx}] <= link.rx_buf_data;
  end

  // descriptors; engine updates come last so they win a same-cycle clash
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      own_reg <= 8'h00;
      host_xy_reg <= 4'h0;
      for (int i = 0; i < 8; i++)
        cnt_reg[i] <= 7'h00;
    end
    else
    begin
      if (init_wr)
      begin
        own_reg[{init_edb, 1'b0}] <= init_own;
        own_reg[{init_edb, 1'b1}] <= init_own;
        host_xy_reg[init_edb] <= 1'b0;
      end
      else if (out_commit && out_free)
      begin
        cnt_reg[host_sel] <= out_cnt;
        own_reg[host_sel] <= 1'b1;
        host_xy_reg[host_edb] <= ~host_xy_reg[host_edb];
      end
      else if (in_release && in_avail)
      begin
        own_reg[host_sel] <= 1'b1;
        host_xy_reg[host_edb] <= ~host_xy_reg[host_edb];
      end
      if (link.tx_desc_wr)
        own_reg[{link.tx_edb, link.tx_xy}] <= 1'b0;
      if (link.rx_desc_wr)
      begin
        cnt_reg[{link.rx_edb, link.rx_xy}] <= link.rx_desc_cnt;
        own_reg[{link.rx_edb, link.rx_xy}] <= 1'b0;
      end
    end
  end

  // each finished buffer flips the engine's buffer choice one cycle later
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_tog_reg <= 1'b0;
      rx_tog_reg <= 1'b0;
    end
    else
    begin
      tx_tog_reg <= link.tx_desc_wr;
      rx_tog_reg <= link.rx_desc_wr;
    end
  end

  // inbound read data registered for the host
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      in_rd_data <= 8'h00;
    else
      in_rd_data <= mem_reg[{host_sel, in_rd_idx}];
  end

  // one-byte transmit holding stage; ready only while empty
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      uart_tx_valid <= 1'b0;
      uart_tx_data <= 8'h00;
    end
    else if (link.ser_tx_wr && !uart_tx_valid)
    begin
      uart_tx_valid <= 1'b1;
      uart_tx_data <= link.ser_tx_data;
    end
    else if (uart_tx_ready)
      uart_tx_valid <= 1'b0;
  end

  // host status and engine-facing views
  assign out_free = ~own_reg[host_sel];
  assign in_avail = ~own_reg[host_sel];
  assign in_cnt = cnt_reg[host_sel];
  assign link.tx_own = own_reg[{link.tx_edb, link.tx_xy}];
  assign link.tx_cnt = cnt_reg[{link.tx_edb, link.tx_xy}];
  assign link.tx_byte = mem_reg[{link.tx_edb, link.tx_xy, link.tx_idx}];
  assign link.tx_xy_toggle = tx_tog_reg;
  assign link.rx_own_x = own_reg[{link.rx_edb, 1'b0}];
  assign link.rx_own_y = own_reg[{link.rx_edb, 1'b1}];
  assign link.rx_xy_toggle = rx_tog_reg;
  assign link.ser_tx_ready = ~uart_tx_valid;
  assign link.ser_rx_data = uart_rx_data;
  assign link.ser_rx_valid = uart_rx_valid;
  assign link.line_err = uart_line_err;
  assign uart_rx_ready = link.ser_rx_rd;

endmodule // buffer_manager

// ==== hdl/transfer_engine.sv ====
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module transfer_engine (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // completion notice per channel, bit 0 outbound, bit 1 inbound
  output logic [1:0] mcu_irq,
  // link to the buffer manager
  dma_link_if.engine link
);
  import dma_pkg::*;

  // ***********************************************************
  // register bus slave
  // ***********************************************************
  logic [7:0] tx_def_reg;
  logic [7:0] tx_csr_reg;
  logic [7:0] rx_def_reg;
  logic [7:0] rx_csr_reg;
  logic [15:0] reg_index;
  logic aligned;
  logic hit_tx_def;
  logic hit_tx_csr;
  logic hit_rx_def;
  logic hit_rx_csr;
  logic mapped;
  logic access;
  logic wr_en;
  logic [2:0] tx_set;
  logic [2:0] rx_set;
  logic [2:0] rx_clr;

  assign reg_index = paddr[17:2];
  assign aligned = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
  assign hit_tx_def = aligned && (reg_index == IDX_TX_DEF);
  assign hit_tx_csr = aligned && (reg_index == IDX_TX_CSR);
  assign hit_rx_def = aligned && (reg_index == IDX_RX_DEF);
  assign hit_rx_csr = aligned && (reg_index == IDX_RX_CSR);
  assign mapped = hit_tx_def || hit_tx_csr || hit_rx_def || hit_rx_csr;
  assign access = psel && penable;
  assign wr_en = access && pwrite && mapped;
  // zero wait states; unmapped addresses answer with an error
  assign pready = access;
  assign pslverr = access && !mapped;

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (1'b1)
        hit_tx_def: prdata <= {24'h000000, tx_def_reg};
        hit_tx_csr: prdata <= {24'h000000, tx_csr_reg};
        hit_rx_def: prdata <= {24'h000000, rx_def_reg};
        hit_rx_csr: prdata <= {24'h000000, rx_csr_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // definition registers; the manager's toggle lands after any write
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_def_reg <= DEF_RESET;
      rx_def_reg <= DEF_RESET;
    end
    else
    begin
      if (wr_en && hit_tx_def)
        tx_def_reg <= (pwdata[7:0] & DEF_WR_MASK);
      if (link.tx_xy_toggle)
        tx_def_reg[DEF_XY_BIT] <= ~((wr_en && hit_tx_def) ? pwdata[DEF_XY_BIT]
                                     : tx_def_reg[DEF_XY_BIT]);
      if (wr_en && hit_rx_def)
        rx_def_reg <= (pwdata[7:0] & DEF_WR_MASK);
      if (link.rx_xy_toggle)
        rx_def_reg[DEF_XY_BIT] <= ~((wr_en && hit_rx_def) ? pwdata[DEF_XY_BIT]
                                     : rx_def_reg[DEF_XY_BIT]);
    end
  end

  // completion codes: write one to clear, a hardware set wins
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_csr_reg <= CSR_RESET;
      rx_csr_reg <= CSR_RESET;
    end
    else
    begin
      tx_csr_reg <= (((wr_en && hit_tx_csr) ?
                    ((pwdata[7:0] & CSR_TOV_MASK) | (tx_csr_reg & CSR_FLAG_MASK & ~pwdata[7:0]))
                    : tx_csr_reg)) | {5'h00, tx_set};
      rx_csr_reg <= ((((wr_en && hit_rx_csr) ?
                    ((pwdata[7:0] & CSR_TOV_MASK) | (rx_csr_reg & CSR_FLAG_MASK & ~pwdata[7:0]))
                    : rx_csr_reg)) & ~{5'h00, rx_clr}) | {5'h00, rx_set};
    end
  end

  // ***********************************************************
  // transaction timers
  // ***********************************************************
  logic [6:0] presc_reg;
  logic tick;
  logic [1:0] tmr_run;
  logic [1:0] tmr_kick;
  logic [1:0] expire;
  logic [3:0] tov [2];

  assign tick = (presc_reg == TICK_LAST);
  assign tov[0] = tx_csr_reg[CSR_TOV_LSB +: 4];
  assign tov[1] = rx_csr_reg[CSR_TOV_LSB +: 4];

  // shared microsecond prescaler
  always_ff @(posedge clk_sys)
  begin
    if (srst || tick)
      presc_reg <= 7'h00;
    else
      presc_reg <= presc_reg + 7'h01;
  end

  // per-channel idle timer, the inbound one restarted on every inbound byte; zero disables it
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_tmr
    logic [3:0] ticks_reg;
    always_ff @(posedge clk_sys)
    begin
      if (srst || !tmr_run[ch] || tmr_kick[ch])
        ticks_reg <= 4'h0;
      else if (tick && (ticks_reg != 4'hF))
        ticks_reg <= ticks_reg + 4'h1;
    end
    assign expire[ch] = (tov[ch] != 4'h0) && (ticks_reg >= tov[ch]);
  end

  // ***********************************************************
  // outbound channel: buffers to serial transmitter
  // ***********************************************************
  tx_state_e tx_state_reg;
  cnt_t tx_cnt_reg;
  cnt_t tx_pos_reg;
  byte_t tx_data_reg;
  logic tx_en;
  logic any_err;

  assign tx_en = tx_def_reg[DEF_EN_BIT];
  assign any_err = |link.line_err;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 7'h00;
      tx_pos_reg <= 7'h00;
      tx_data_reg <= 8'h00;
    end
    else if (!tx_en)
      tx_state_reg <= TX_IDLE;
    else
    begin
      case (tx_state_reg)
        TX_IDLE: tx_state_reg <= TX_LOOK;
        TX_LOOK:
        begin
          if (link.tx_own)
          begin
            tx_cnt_reg <= link.tx_cnt;
            tx_pos_reg <= 7'h00;
            tx_state_reg <= (link.tx_cnt == 7'h00) ? TX_DONE : TX_FETCH;
          end
          else if (expire[0])
            tx_state_reg <= TX_HALT;
        end
        TX_FETCH:
        begin
          tx_data_reg <= link.tx_byte;
          tx_state_reg <= TX_PUSH;
        end
        TX_PUSH:
        begin
          // line errors hold the byte back until they clear
          if (link.ser_tx_ready && !any_err)
          begin
            tx_pos_reg <= tx_pos_reg + 7'h01;
            tx_state_reg <= (tx_pos_reg + 7'h01 == tx_cnt_reg) ? TX_DONE : TX_FETCH;
          end
        end
        TX_DONE:
          tx_state_reg <= ((tx_cnt_reg < PKT_SIZE) || !tx_def_reg[DEF_CONT_BIT])
                          ? TX_HALT : TX_WAIT;
        TX_WAIT: tx_state_reg <= TX_LOOK;
        TX_HALT: tx_state_reg <= TX_HALT;
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  assign link.tx_edb = tx_def_reg[DEF_EDB_LSB +: 2];
  assign link.tx_xy = tx_def_reg[DEF_XY_BIT];
  assign link.tx_idx = tx_pos_reg[5:0];
  assign link.tx_desc_wr = (tx_state_reg == TX_DONE);
  assign link.ser_tx_data = tx_data_reg;
  assign link.ser_tx_wr = (tx_state_reg == TX_PUSH) && !any_err;
  assign tx_set[CSR_OVR_BIT] = 1'b0;
  assign tx_set[CSR_TO_BIT] = tx_en && (tx_state_reg == TX_LOOK) && !link.tx_own && expire[0];
  assign tx_set[CSR_PP_BIT] = tx_en && (tx_state_reg == TX_DONE) && (tx_cnt_reg < PKT_SIZE);
  assign tmr_run[0] = (tx_state_reg == TX_LOOK);
  assign tmr_kick[0] = 1'b0;

  // ***********************************************************
  // inbound channel: serial receiver to buffers
  // ***********************************************************
  rx_state_e rx_state_reg;
  cnt_t rx_pos_reg;
  byte_t rx_data_reg;
  logic rx_part_reg;
  logic rx_en;
  logic rx_own_sel;
  logic rx_overrun;

  assign rx_en = rx_def_reg[DEF_EN_BIT];
  assign rx_own_sel = rx_def_reg[DEF_XY_BIT] ? link.rx_own_y : link.rx_own_x;
  assign rx_overrun = !link.rx_own_x && !link.rx_own_y;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_state_reg <= RX_IDLE;
      rx_pos_reg <= 7'h00;
      rx_data_reg <= 8'h00;
      rx_part_reg <= 1'b0;
    end
    else if (!rx_en)
      rx_state_reg <= RX_IDLE;
    else
    begin
      case (rx_state_reg)
        RX_IDLE: rx_state_reg <= RX_LOOK;
        RX_LOOK:
        begin
          if (rx_own_sel)
          begin
            rx_pos_reg <= 7'h00;
            rx_part_reg <= 1'b0;
            rx_state_reg <= RX_FILL;
          end
          else if (expire[1] && rx_overrun)
            rx_state_reg <= RX_HALT;
        end
        RX_FILL:
        begin
          if (any_err)
            rx_state_reg <= RX_HALT;
          else if (link.ser_rx_valid)
          begin
            rx_data_reg <= link.ser_rx_data;
            rx_state_reg <= RX_STORE;
          end
          else if (expire[1])
          begin
            rx_part_reg <= 1'b1;
            rx_state_reg <= RX_COMMIT;
          end
        end
        RX_STORE:
        begin
          rx_pos_reg <= rx_pos_reg + 7'h01;
          rx_state_reg <= (rx_pos_reg + 7'h01 == PKT_SIZE) ? RX_COMMIT : RX_FILL;
        end
        RX_COMMIT:
          rx_state_reg <= (rx_part_reg || !rx_def_reg[DEF_CONT_BIT])
                          ? RX_HALT : RX_WAIT;
        RX_WAIT: rx_state_reg <= RX_LOOK;
        RX_HALT: rx_state_reg <= RX_HALT;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  assign link.rx_edb = rx_def_reg[DEF_EDB_LSB +: 2];
  assign link.rx_xy = rx_def_reg[DEF_XY_BIT];
  assign link.rx_idx = rx_pos_reg[5:0];
  assign link.rx_buf_wr = (rx_state_reg == RX_STORE);
  assign link.rx_buf_data = rx_data_reg;
  assign link.rx_desc_wr = (rx_state_reg == RX_COMMIT);
  assign link.rx_desc_cnt = rx_pos_reg;
  assign link.ser_rx_rd = rx_en && (rx_state_reg == RX_FILL) && !any_err
                          && link.ser_rx_valid;

  // timeout and overrun codes for the inbound terminations
  logic rx_short;
  logic rx_ovr_stop;
  logic rx_err_stop;
  assign rx_short = rx_en && (rx_state_reg == RX_FILL) && !any_err
                    && !link.ser_rx_valid && expire[1];
  assign rx_ovr_stop = rx_en && (rx_state_reg == RX_LOOK) && !rx_own_sel
                       && expire[1] && rx_overrun;
  assign rx_err_stop = rx_en && (rx_state_reg == RX_FILL) && any_err;
  assign rx_set[CSR_OVR_BIT] = rx_ovr_stop;
  assign rx_set[CSR_TO_BIT] = rx_short || rx_ovr_stop || rx_err_stop;
  assign rx_set[CSR_PP_BIT] = 1'b0;
  assign rx_clr = {1'b0, 1'b0, rx_short || rx_err_stop};
  assign tmr_run[1] = (rx_state_reg == RX_FILL) || (rx_state_reg == RX_LOOK);
  assign tmr_kick[1] = link.ser_rx_rd;

  // completion notices; a receiver error stays quiet here
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mcu_irq <= 2'b00;
    else
      mcu_irq <= {rx_short || rx_ovr_stop, tx_set[CSR_PP_BIT] || tx_set[CSR_TO_BIT]};
  end

endmodule // transfer_engine

// ==== tb/dma_link_sva.sv ====
`timescale 1ns/1ps
// ****************
// link checker
// ****************
module dma_link_sva (
  // system
  input wire logic clk_sys,
  input wire logic srst,
  // serial side
  input wire logic ser_tx_wr,
  input wire logic [3:0] line_err,
  input wire logic ser_rx_rd,
  input wire logic ser_rx_valid,
  input wire dma_pkg::byte_t ser_rx_data,
  // buffer side
  input wire logic rx_buf_wr,
  input wire dma_pkg::byte_t rx_buf_data,
  input wire dma_pkg::idx_t rx_idx,
  input wire logic rx_desc_wr,
  input wire dma_pkg::cnt_t rx_desc_cnt,
  input wire logic rx_xy_toggle,
  input wire logic tx_desc_wr,
  input wire logic tx_xy_toggle
);
  import dma_pkg::*;
  // single domain, so one clock and one disable
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_tx_err; ser_tx_wr |-> line_err == 4'h0; endproperty
  a_tx_err: assert property (p_tx_err) else $error("tx write in line error");
  property p_rx_take; ser_rx_rd |-> ser_rx_valid && line_err == 4'h0; endproperty
  a_rx_take: assert property (p_rx_take) else $error("rx read without data");
  property p_rx_store; ser_rx_rd |=> rx_buf_wr; endproperty
  a_rx_store: assert property (p_rx_store) else $error("rx byte not stored");
  property p_rx_data; rx_buf_wr |-> rx_buf_data == $past(ser_rx_data); endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx stored wrong byte");
  property p_rx_gap; ser_rx_rd |=> !ser_rx_rd; endproperty
  a_rx_gap: assert property (p_rx_gap) else $error("rx read twice in a row");
  property p_tx_tgl; tx_desc_wr |=> tx_xy_toggle; endproperty
  a_tx_tgl: assert property (p_tx_tgl) else $error("tx toggle missing");
  property p_rx_tgl; rx_desc_wr |=> rx_xy_toggle; endproperty
  a_rx_tgl: assert property (p_rx_tgl) else $error("rx toggle missing");
  // a full block must be handed over at once with its count
  property p_rx_full; rx_buf_wr && rx_idx == 6'h3F |=> rx_desc_wr && rx_desc_cnt == 7'h40;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("full block not committed");
  c_rx_commit: cover property (rx_desc_wr);
  c_tx_done: cover property (tx_desc_wr);
  c_rx_full: cover property (rx_desc_wr && rx_desc_cnt == 7'h40);
endmodule // dma_link_sva

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench;
  import dma_pkg::*;
  // ****************
  // signals
  // ****************
  localparam logic [31:0] A_TXD = {14'h0, IDX_TX_DEF, 2'h0};
  localparam logic [31:0] A_TXC = {14'h0, IDX_TX_CSR, 2'h0};
  localparam logic [31:0] A_RXD = {14'h0, IDX_RX_DEF, 2'h0};
  localparam logic [31:0] A_RXC = {14'h0, IDX_RX_CSR, 2'h0};
  logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [31:0] paddr, pwdata, prdata, rd_data;
  logic [1:0] mcu_irq;
  logic init_wr, init_own, out_wr, out_commit, out_free, in_avail, in_release;
  edb_t init_edb, host_edb;
  idx_t out_idx, in_rd_idx;
  byte_t out_data, in_rd_data, uart_tx_data, uart_rx_data;
  cnt_t out_cnt, in_cnt;
  logic uart_tx_valid, uart_tx_ready, uart_rx_valid, uart_rx_ready;
  logic [3:0] uart_line_err;
  int mismatches, samples_checked, cyc, rx_n, irq_n [2];
  byte_t tx_q [$];
  dma_link_if link();
  transfer_engine u_transfer_engine (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mcu_irq, .link);
  buffer_manager u_buffer_manager (.clk_sys, .srst, .init_wr, .init_edb, .init_own,
    .host_edb, .out_wr, .out_idx, .out_data, .out_commit, .out_cnt, .out_free, .in_avail,
    .in_cnt, .in_rd_idx, .in_rd_data, .in_release, .uart_tx_data, .uart_tx_valid,
    .uart_tx_ready, .uart_rx_data, .uart_rx_valid, .uart_rx_ready, .uart_line_err, .link);
  dma_link_sva u_dma_link_sva (.clk_sys, .srst, .ser_tx_wr(link.ser_tx_wr),
    .line_err(link.line_err), .ser_rx_rd(link.ser_rx_rd), .ser_rx_valid(link.ser_rx_valid),
    .ser_rx_data(link.ser_rx_data), .rx_buf_wr(link.rx_buf_wr), .rx_idx(link.rx_idx),
    .rx_buf_data(link.rx_buf_data), .rx_desc_wr(link.rx_desc_wr),
    .rx_desc_cnt(link.rx_desc_cnt), .rx_xy_toggle(link.rx_xy_toggle),
    .tx_desc_wr(link.tx_desc_wr), .tx_xy_toggle(link.tx_xy_toggle));
  // ****************
  // clock, monitors
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // serial sink, irq counters and hang guard in one place
  always @(posedge clk_sys)
  begin
    cyc++;
    if (uart_tx_valid && uart_tx_ready) tx_q.push_back(uart_tx_data);
    if (mcu_irq[0] === 1'b1) irq_n[0]++;
    if (mcu_irq[1] === 1'b1) irq_n[1]++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  // serial source: byte n carries value n, stops after 66
  always @(posedge clk_sys)
    if (uart_rx_valid && uart_rx_ready)
    begin
      rx_n <= rx_n + 1;
      uart_rx_data <= uart_rx_data + 8'h01;
      if (rx_n == 65) uart_rx_valid <= 1'b0;
    end
  // ****************
  // tasks
  // ****************
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_data, e)
  endtask
  // pulses that the host side issues
  task automatic host(input int k);
    @(posedge clk_sys);
    if (k == 0) init_wr <= 1'b1;
    if (k == 1) out_commit <= 1'b1;
    if (k == 2) in_release <= 1'b1;
    @(posedge clk_sys);
    {init_wr, out_commit, in_release} <= 3'h0;
  endtask
  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************
  // stimulus
  // ****************
  initial
  begin
    {psel, penable, pwrite, init_wr, out_wr, out_commit, in_release, uart_rx_valid} = '0;
    {paddr, pwdata, out_idx, in_rd_idx, out_data, out_cnt, uart_rx_data} = '0;
    {uart_line_err, rx_n, init_own, init_edb} = '0;
    host_edb = 2'h1;
    uart_tx_ready = 1'b1;
    srst = 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    chk_rd(A_TXD, 32'h0);
    chk_rd(A_TXC, 32'h0);
    chk_rd(A_RXD, 32'h0);
    chk_rd(A_RXC, 32'h0);
    chk_rd(32'h0003_FF88, 32'h0);
    `CHK(rd_err, 1'b1)
    // outbound: three-byte short packet from block one
    host(0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys);
      out_wr <= 1'b1;
      out_idx <= 6'(i);
      out_data <= 8'hA0 + 8'(i);
    end
    @(posedge clk_sys);
    out_wr <= 1'b0;
    out_cnt <= 7'h03;
    host(1);
    apb(1'b1, A_TXD, 32'h81);
    while (irq_n[0] == 0) @(posedge clk_sys);
    `CHK(tx_q.size(), 3)
    for (int i = 0; i < 3; i++) `CHK(tx_q[i], 8'hA0 + 8'(i))
    chk_rd(A_TXC, 32'h04);
    apb(1'b1, A_TXC, 32'h04);
    chk_rd(A_TXC, 32'h00);
    // inbound: continuous on block two, full block then short timeout
    host_edb <= 2'h2;
    init_edb <= 2'h2;
    init_own <= 1'b1;
    host(0);
    apb(1'b1, A_RXC, 32'h08);
    apb(1'b1, A_RXD, 32'hA2);
    uart_rx_valid <= 1'b1;
    while (irq_n[1] == 0) @(posedge clk_sys);
    `CHK(rx_n, 66)
    chk_rd(A_RXC, 32'h0A);
    `CHK(in_avail, 1'b1)
    `CHK(in_cnt, 7'h40)
    in_rd_idx <= 6'h05;
    repeat (2) @(posedge clk_sys);
    `CHK(in_rd_data, 8'h05)
    host(2);
    // the pointer flips at the edge that ends the task; let it settle
    @(posedge clk_sys);
    `CHK(in_cnt, 7'h02)
    in_rd_idx <= 6'h01;
    repeat (2) @(posedge clk_sys);
    `CHK(in_rd_data, 8'h41)
    // receiver error: halts, no irq, enable kept
    apb(1'b1, A_RXD, 32'h00);
    apb(1'b1, A_RXC, 32'h0F);
    host(0);
    apb(1'b1, A_RXD, 32'h82);
    uart_line_err <= 4'h4;
    repeat (10) @(posedge clk_sys);
    chk_rd(A_RXC, 32'h0A);
    chk_rd(A_RXD, 32'h82);
    `CHK(irq_n[1], 1)
    // overrun: both buffers still with the host when the timer runs out
    uart_line_err <= 4'h0;
    apb(1'b1, A_RXD, 32'h00);
    apb(1'b1, A_RXC, 32'h0F);
    init_own <= 1'b0;
    host(0);
    apb(1'b1, A_RXD, 32'h82);
    while (irq_n[1] < 2) @(posedge clk_sys);
    chk_rd(A_RXC, 32'h0B);
    `CHK(irq_n[1], 2)
    test_done();
  end
endmodule // testbench
